// ===== common/artt_map.svh
// register offsets, field positions, reset values and divider counts
`ifndef ARTT_MAP_SVH
`define ARTT_MAP_SVH

// byte offsets of the register words
`define ARTT_OFS_CONTROL    8'h00
`define ARTT_OFS_CLKSEL     8'h04
`define ARTT_OFS_COUNT      8'h08
`define ARTT_OFS_RELOAD     8'h0c
`define ARTT_OFS_STATUS     8'h10
`define ARTT_OFS_MASK       8'h14

// timer_two_control fields
`define ARTT_CTL_HIGH_FLAG  7
`define ARTT_CTL_LOW_FLAG   6
`define ARTT_CTL_LOW_IRQ_EN 5
`define ARTT_CTL_SPLIT      3
`define ARTT_CTL_RUN        2
`define ARTT_CTL_EXT_SRC    0

// clock_select_register fields
`define ARTT_CKS_HIGH_FAST  1
`define ARTT_CKS_LOW_FAST   0

// mask register: timer interrupt enable sits on the high flag's bit
`define ARTT_MSK_TIMER_EN   7

// reset values
`define ARTT_RST_BYTE       8'h00
`define ARTT_RST_COUNT      16'h0000

// divider counts
`define ARTT_CORE_DIV       4'hc
`define ARTT_EXT_DIV        3'h7

// axi responses
`define ARTT_RESP_OKAY      2'h0
`define ARTT_RESP_SLVERR    2'h2

`endif

// ===== common/artt_pkg.sv
// types shared by the auto-reload timer
package artt_pkg;

  // register selected by a bus address
  typedef enum logic [2:0] {
    REG_CONTROL,
    REG_CLKSEL,
    REG_COUNT,
    REG_RELOAD,
    REG_STATUS,
    REG_MASK,
    REG_NONE
  } artt_reg_t;

endpackage : artt_pkg

// ===== rtl/artt_timer.sv
// auto-reload timer two with an axi4-lite register slave
// ****************************************************************
// ****************************************************************
`include "artt_map.svh"

module artt_timer (
  input  wire logic        aclk,         // core clock, 40 mhz
  input  wire logic        aresetn,      // synchronous reset
  input  wire logic        ext_osc,      // external oscillator pin
  input  wire logic [7:0]  awaddr,       // write address
  input  wire logic        awvalid,      // write address valid
  output logic             awready,      // write address ready
  input  wire logic [31:0] wdata,        // write data
  input  wire logic [3:0]  wstrb,        // write byte strobes
  input  wire logic        wvalid,       // write data valid
  output logic             wready,       // write data ready
  output logic [1:0]       bresp,        // write response
  output logic             bvalid,       // write response valid
  input  wire logic        bready,       // write response ready
  input  wire logic [7:0]  araddr,       // read address
  input  wire logic        arvalid,      // read address valid
  output logic             arready,      // read address ready
  output logic [31:0]      rdata,        // read data
  output logic [1:0]       rresp,        // read response
  output logic             rvalid,       // read data valid
  input  wire logic        rready,       // read data ready
  output logic             irq           // interrupt request, level
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // address to register decode, shared by read and write paths
  function automatic artt_pkg::artt_reg_t reg_of(input logic [7:0] a);
    case (a)
      `ARTT_OFS_CONTROL: reg_of = artt_pkg::REG_CONTROL;
      `ARTT_OFS_CLKSEL:  reg_of = artt_pkg::REG_CLKSEL;
      `ARTT_OFS_COUNT:   reg_of = artt_pkg::REG_COUNT;
      `ARTT_OFS_RELOAD:  reg_of = artt_pkg::REG_RELOAD;
      `ARTT_OFS_STATUS:  reg_of = artt_pkg::REG_STATUS;
      `ARTT_OFS_MASK:    reg_of = artt_pkg::REG_MASK;
      default:           reg_of = artt_pkg::REG_NONE;
    endcase
  endfunction : reg_of

  // count-clock pick: fast wins, else external or core over 12
  function automatic logic pick_tick(input logic fast, input logic ext,
                                     input logic t12, input logic tx);
    pick_tick = fast | (ext ? tx : t12);
  endfunction : pick_tick

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]  cnt_lo_reg, cnt_hi_reg, rl_lo_reg, rl_hi_reg;
  logic [7:0]  cnt_lo_next, cnt_hi_next;
  logic        high_flag_reg, low_flag_reg;
  logic        high_flag_next, low_flag_next;
  logic        low_irq_en_reg, split_reg, run_reg, ext_sel_reg;
  logic        high_fast_reg, low_fast_reg, timer_en_reg;
  logic [3:0]  div12_reg;
  logic        ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_lvl_reg;
  logic [2:0]  ext_div_reg;
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        awready_reg, wready_reg, bvalid_reg, arready_reg;
  logic        rvalid_reg, irq_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic        set_hi, set_lo;

  // ****************************************************************
  // count clocks
  // ****************************************************************
  wire tick12   = (div12_reg == (`ARTT_CORE_DIV - 4'h1));
  wire ext_agr  = (ext_s2_reg == ext_s3_reg);
  wire ext_rise = ext_agr & ext_s3_reg & ~ext_lvl_reg;
  wire ext_tick = ext_rise & (ext_div_reg == `ARTT_EXT_DIV);
  wire tick_h   = pick_tick(high_fast_reg, ext_sel_reg,
                            tick12, ext_tick);
  wire tick_l   = pick_tick(low_fast_reg, ext_sel_reg,
                            tick12, ext_tick);

  // core prescaler and external synchroniser / divider by 8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div12_reg   <= 4'h0;
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      ext_lvl_reg <= 1'b0;
      ext_div_reg <= 3'h0;
    end else begin
      div12_reg   <= tick12 ? 4'h0 : div12_reg + 4'h1;
      ext_s1_reg  <= ext_osc;
      ext_s2_reg  <= ext_s1_reg;
      ext_s3_reg  <= ext_s2_reg;
      if (ext_agr) begin
        ext_lvl_reg <= ext_s3_reg;
      end
      if (ext_rise) begin
        ext_div_reg <= ext_div_reg + 3'h1;
      end
    end
  end

  // ****************************************************************
  // bus write side
  // ****************************************************************
  wire aw_take = awvalid & awready_reg;
  wire w_take  = wvalid & wready_reg;
  wire do_wr   = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  artt_pkg::artt_reg_t wsel;
  assign wsel  = reg_of(aw_addr_reg);
  wire wr_ctl  = do_wr & (wsel == artt_pkg::REG_CONTROL) & w_strb_reg[0];
  wire wr_cks  = do_wr & (wsel == artt_pkg::REG_CLKSEL) & w_strb_reg[0];
  wire wr_cl   = do_wr & (wsel == artt_pkg::REG_COUNT) & w_strb_reg[0];
  wire wr_ch   = do_wr & (wsel == artt_pkg::REG_COUNT) & w_strb_reg[1];
  wire wr_rl   = do_wr & (wsel == artt_pkg::REG_RELOAD) & w_strb_reg[0];
  wire wr_rh   = do_wr & (wsel == artt_pkg::REG_RELOAD) & w_strb_reg[1];
  wire wr_sts  = do_wr & (wsel == artt_pkg::REG_STATUS) & w_strb_reg[0];
  wire wr_msk  = do_wr & (wsel == artt_pkg::REG_MASK) & w_strb_reg[0];
  wire wr_cnt  = wr_cl | wr_ch;
  // clears: control write of zero, or status write of one
  wire clr_hi  = (wr_ctl & ~w_data_reg[`ARTT_CTL_HIGH_FLAG]) |
                 (wr_sts & w_data_reg[`ARTT_CTL_HIGH_FLAG]);
  wire clr_lo  = (wr_ctl & ~w_data_reg[`ARTT_CTL_LOW_FLAG]) |
                 (wr_sts & w_data_reg[`ARTT_CTL_LOW_FLAG]);
  wire sw_hi   = wr_ctl & w_data_reg[`ARTT_CTL_HIGH_FLAG];
  wire sw_lo   = wr_ctl & w_data_reg[`ARTT_CTL_LOW_FLAG];

  // address and data are caught independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `ARTT_RESP_OKAY;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr_reg <= awaddr;
      end
      if (w_take) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      aw_hold_reg <= aw_take | (aw_hold_reg & ~do_wr);
      w_hold_reg  <= w_take | (w_hold_reg & ~do_wr);
      awready_reg <= ~(aw_take | (aw_hold_reg & ~do_wr));
      wready_reg  <= ~(w_take | (w_hold_reg & ~do_wr));
      if (do_wr) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wsel == artt_pkg::REG_NONE) ?
                      `ARTT_RESP_SLVERR : `ARTT_RESP_OKAY;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_irq_en_reg <= 1'b0;
      split_reg      <= 1'b0;
      run_reg        <= 1'b0;
      ext_sel_reg    <= 1'b0;
      high_fast_reg  <= 1'b0;
      low_fast_reg   <= 1'b0;
      timer_en_reg   <= 1'b0;
      rl_lo_reg      <= `ARTT_RST_BYTE;
      rl_hi_reg      <= `ARTT_RST_BYTE;
    end else begin
      if (wr_ctl) begin
        low_irq_en_reg <= w_data_reg[`ARTT_CTL_LOW_IRQ_EN];
        split_reg      <= w_data_reg[`ARTT_CTL_SPLIT];
        run_reg        <= w_data_reg[`ARTT_CTL_RUN];
        ext_sel_reg    <= w_data_reg[`ARTT_CTL_EXT_SRC];
      end
      if (wr_cks) begin
        high_fast_reg <= w_data_reg[`ARTT_CKS_HIGH_FAST];
        low_fast_reg  <= w_data_reg[`ARTT_CKS_LOW_FAST];
      end
      if (wr_msk) begin
        timer_en_reg <= w_data_reg[`ARTT_MSK_TIMER_EN];
      end
      if (wr_rl) begin
        rl_lo_reg <= w_data_reg[7:0];
      end
      if (wr_rh) begin
        rl_hi_reg <= w_data_reg[15:8];
      end
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************
  wire lo_full = (cnt_lo_reg == 8'hff);
  wire hi_full = (cnt_hi_reg == 8'hff);

  // next count; a software write to a byte overrides the step
  always_comb begin
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    set_hi      = 1'b0;
    set_lo      = 1'b0;
    if (!split_reg) begin
      if (run_reg & tick_l) begin
        set_lo = lo_full;
        if (lo_full & hi_full) begin
          cnt_lo_next = rl_lo_reg;
          cnt_hi_next = rl_hi_reg;
          set_hi      = 1'b1;
        end else begin
          {cnt_hi_next, cnt_lo_next} =
            {cnt_hi_reg, cnt_lo_reg} + 16'h0001;
        end
      end
    end else begin
      if (tick_l) begin
        set_lo      = lo_full;
        cnt_lo_next = lo_full ? rl_lo_reg : cnt_lo_reg + 8'h01;
      end
      if (run_reg & tick_h) begin
        set_hi      = hi_full;
        cnt_hi_next = hi_full ? rl_hi_reg : cnt_hi_reg + 8'h01;
      end
    end
    if (wr_cl) begin
      cnt_lo_next = w_data_reg[7:0];
    end
    if (wr_ch) begin
      cnt_hi_next = w_data_reg[15:8];
    end
  end

  // flags hold until software clears; a wrap in that cycle wins
  assign high_flag_next = set_hi | sw_hi |
                          (high_flag_reg & ~clr_hi);
  assign low_flag_next  = set_lo | sw_lo |
                          (low_flag_reg & ~clr_lo);

  // timer interrupt, low wrap only when also enabled
  wire irq_next = timer_en_reg &
                  (high_flag_reg | (low_irq_en_reg & low_flag_reg));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_lo_reg    <= `ARTT_RST_BYTE;
      cnt_hi_reg    <= `ARTT_RST_BYTE;
      high_flag_reg <= 1'b0;
      low_flag_reg  <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      cnt_lo_reg    <= cnt_lo_next;
      cnt_hi_reg    <= cnt_hi_next;
      high_flag_reg <= high_flag_next;
      low_flag_reg  <= low_flag_next;
      irq_reg       <= irq_next;
    end
  end

  // ****************************************************************
  // bus read side
  // ****************************************************************
  artt_pkg::artt_reg_t rsel;
  assign rsel = reg_of(araddr);
  wire ar_take = arvalid & arready_reg;
  wire [31:0] ctl_word = {24'h0, high_flag_reg, low_flag_reg,
                          low_irq_en_reg, 1'b0, split_reg, run_reg,
                          1'b0, ext_sel_reg};
  wire [31:0] rd_word =
    (rsel == artt_pkg::REG_CONTROL) ? ctl_word :
    (rsel == artt_pkg::REG_CLKSEL)  ? {30'h0, high_fast_reg,
                                       low_fast_reg} :
    (rsel == artt_pkg::REG_COUNT)   ? {16'h0, cnt_hi_reg, cnt_lo_reg} :
    (rsel == artt_pkg::REG_RELOAD)  ? {16'h0, rl_hi_reg, rl_lo_reg} :
    (rsel == artt_pkg::REG_STATUS)  ? {24'h0, high_flag_reg,
                                       low_flag_reg, 6'h00} :
    (rsel == artt_pkg::REG_MASK)    ? {24'h0, timer_en_reg, 7'h00} :
                                      32'h0000_0000;

  // one read in flight; data captured as the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `ARTT_RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= (rsel == artt_pkg::REG_NONE) ?
                     `ARTT_RESP_SLVERR : `ARTT_RESP_OKAY;
    end else if (rvalid_reg & rready) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;
  assign irq     = irq_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wrap16;
    !split_reg && run_reg && tick_l && lo_full && hi_full && !wr_cnt;
  endsequence
  sequence s_reloaded16;
    cnt_lo_reg == $past(rl_lo_reg) && cnt_hi_reg == $past(rl_hi_reg)
      && high_flag_reg;
  endsequence

  property p_wrap16;
    s_wrap16 |=> s_reloaded16;
  endproperty
  a_wrap16: assert property (p_wrap16)
    else $error("16-bit wrap did not reload or flag");

  property p_hold16;
    !split_reg && !run_reg && !wr_cnt |=>
      $stable({cnt_hi_reg, cnt_lo_reg});
  endproperty
  a_hold16: assert property (p_hold16)
    else $error("16-bit counter moved while stopped");

  property p_low_split;
    split_reg && tick_l && lo_full && !wr_cl |=>
      cnt_lo_reg == $past(rl_lo_reg) && low_flag_reg;
  endproperty
  a_low_split: assert property (p_low_split)
    else $error("low half did not reload on wrap");

  property p_low_free;
    split_reg && !run_reg && tick_l && !lo_full && !wr_cl |=>
      cnt_lo_reg == $past(cnt_lo_reg) + 8'h01;
  endproperty
  a_low_free: assert property (p_low_free)
    else $error("low half stalled by run bit");

  property p_high_gate;
    split_reg && !run_reg && !wr_ch |=> $stable(cnt_hi_reg);
  endproperty
  a_high_gate: assert property (p_high_gate)
    else $error("high half moved while stopped");

  property p_high_fast;
    split_reg && run_reg && high_fast_reg && !hi_full && !wr_ch |=>
      cnt_hi_reg == $past(cnt_hi_reg) + 8'h01;
  endproperty
  a_high_fast: assert property (p_high_fast)
    else $error("fast high half missed a core clock");

  // twelve cycles apart: eleven quiet cycles, then the next tick
  property p_div12;
    tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12;
  endproperty
  a_div12: assert property (p_div12)
    else $error("core over 12 tick spacing wrong");

  property p_ext_gap;
    ext_tick |=> !ext_tick [*8];
  endproperty
  a_ext_gap: assert property (p_ext_gap)
    else $error("external tick faster than divided rate");

  property p_low16;
    !split_reg && run_reg && tick_l && lo_full && !clr_lo |=>
      low_flag_reg;
  endproperty
  a_low16: assert property (p_low16)
    else $error("low flag missed in 16-bit mode");

  property p_set_wins;
    (set_hi && clr_hi) || (set_lo && clr_lo) |=>
      (high_flag_reg || !$past(set_hi)) && (low_flag_reg || !$past(set_lo));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a same-cycle set");

  property p_sticky;
    high_flag_reg && !clr_hi |=> high_flag_reg;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("high flag dropped without a clear");

  property p_irq_high;
    timer_en_reg && high_flag_reg ##1 timer_en_reg |-> irq;
  endproperty
  a_irq_high: assert property (p_irq_high)
    else $error("no interrupt for high flag");

  property p_irq_low;
    timer_en_reg && low_irq_en_reg && low_flag_reg |=> irq;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("no interrupt for low flag");

  property p_no_low_irq;
    !low_irq_en_reg && !high_flag_reg |=> !irq;
  endproperty
  a_no_low_irq: assert property (p_no_low_irq)
    else $error("low wrap interrupt without enable");

endmodule : artt_timer

// ===== testbench/test_auto_reload_timer_two.sv
// self-checking bench for the auto-reload timer two
`include "artt_map.svh"

module test_auto_reload_timer_two;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk, aresetn, ext_osc, awvalid, wvalid, bready;
  logic        arvalid, rready, awready, wready, bvalid, arready;
  logic        rvalid, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          n_mismatch, n_compared;

  artt_timer uut (
    .aclk(aclk), .aresetn(aresetn), .ext_osc(ext_osc),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq)
  );

  // ****************************************************************
  // clocks: core at 25 ns, oscillator pin toggled every four core edges
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // eight core cycles per pin period keeps it well below aclk / 4
  initial begin
    ext_osc = 1'b0;
    forever begin
      repeat (4) @(posedge aclk);
      ext_osc <= ~ext_osc;
    end
  end

  // ****************************************************************
  // reporting and bus tasks
  // ****************************************************************
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic hang(input string what);
    n_mismatch++;
    $display("BAD %0t timeout %s", $time, what);
    final_report();
  endtask : hang

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      n_mismatch++;
    end
  endtask : cmp

  // a leading edge keeps two tasks from driving one signal in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    b_ok  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40 && !b_ok; n++) begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        b_ok = 1'b1;
        bready <= 1'b0;
        cmp(32'(bresp), 32'(er), "write response");
      end
    end
    if (!b_ok) hang("write");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] rr);
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok  = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40 && !r_ok; n++) begin
      @(posedge aclk);
      if (!ar_ok && arready) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        r_ok = 1'b1;
        v = rdata;
        rr = rresp;
        rready <= 1'b0;
      end
    end
    if (!r_ok) hang("read");
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d, r);
    cmp(d, exp, "register read");
  endtask : rdc

  // flags only show once the counter has wrapped, so poll a bounded time
  task automatic poll(input int idx);
    for (int n = 0; n < 300; n++) begin
      rd(`ARTT_OFS_CONTROL, d, r);
      if (d[idx] === 1'b1) return;
    end
    hang("flag");
  endtask : poll

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rdc(`ARTT_OFS_CONTROL, 32'h0);
    rdc(`ARTT_OFS_COUNT, 32'h0);
    rdc(`ARTT_OFS_RELOAD, 32'h0);
    rdc(`ARTT_OFS_MASK, 32'h0);
    rdc(`ARTT_OFS_CLKSEL, 32'h0);
    rdc(`ARTT_OFS_STATUS, 32'h0);
    rd(8'h40, d, r);
    cmp(32'(r), 32'(`ARTT_RESP_SLVERR), "unmapped read");
    wr(8'h40, 32'h1, `ARTT_RESP_SLVERR);
    wr(`ARTT_OFS_COUNT, 32'ha55a, `ARTT_RESP_OKAY);
    rdc(`ARTT_OFS_COUNT, 32'ha55a);
  endtask : t_reset

  task automatic t_wide();
    logic [31:0] held;
    wr(`ARTT_OFS_CLKSEL, 32'h1, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_RELOAD, 32'h1234, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_COUNT, 32'hfff0, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_MASK, 32'h80, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_CONTROL, 32'h04, `ARTT_RESP_OKAY);
    poll(`ARTT_CTL_HIGH_FLAG);
    wr(`ARTT_OFS_CONTROL, 32'hc0, `ARTT_RESP_OKAY);
    rd(`ARTT_OFS_COUNT, held, r);
    cmp(32'(held >= 32'h1234 && held < 32'h1280), 32'h1, "reload");
    rdc(`ARTT_OFS_CONTROL, 32'hc0);
    cmp(32'(irq), 32'h1, "wrap irq");
    repeat (20) @(posedge aclk);
    rdc(`ARTT_OFS_COUNT, held);
    rdc(`ARTT_OFS_CONTROL, 32'hc0);
    wr(`ARTT_OFS_STATUS, 32'h80, `ARTT_RESP_OKAY);
    rdc(`ARTT_OFS_CONTROL, 32'h40);
    repeat (2) @(posedge aclk);
    cmp(32'(irq), 32'h0, "low irq off");
    wr(`ARTT_OFS_CONTROL, 32'h60, `ARTT_RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(32'(irq), 32'h1, "low irq on");
    wr(`ARTT_OFS_STATUS, 32'hc0, `ARTT_RESP_OKAY);
    rdc(`ARTT_OFS_CONTROL, 32'h20);
  endtask : t_wide

  task automatic t_split();
    wr(`ARTT_OFS_CONTROL, 32'h08, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_CLKSEL, 32'h3, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_COUNT, 32'h55f8, `ARTT_RESP_OKAY);
    poll(`ARTT_CTL_LOW_FLAG);
    rd(`ARTT_OFS_COUNT, d, r);
    cmp(32'(d[15:8]), 32'h55, "high held");
    cmp(32'(d[7:0] >= 8'h34 && d[7:0] < 8'h60), 32'h1, "low rl");
    rdc(`ARTT_OFS_CONTROL, 32'h48);
    wr(`ARTT_OFS_CONTROL, 32'h4c, `ARTT_RESP_OKAY);
    poll(`ARTT_CTL_HIGH_FLAG);
    rd(`ARTT_OFS_COUNT, d, r);
    cmp(32'(d[15:8] >= 8'h12 && d[15:8] < 8'h30), 32'h1, "hi rl");
    cmp(32'(irq), 32'h1, "high irq");
    wr(`ARTT_OFS_STATUS, 32'h80, `ARTT_RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(32'(irq), 32'h0, "low only");
    wr(`ARTT_OFS_CONTROL, 32'h6c, `ARTT_RESP_OKAY);
    repeat (2) @(posedge aclk);
    cmp(32'(irq), 32'h1, "either half");
    rdc(`ARTT_OFS_CONTROL, 32'h6c);
    wr(`ARTT_OFS_CONTROL, 32'h08, `ARTT_RESP_OKAY);
  endtask : t_split

  // divided counts allow a tick either way, the fast count up to ten ticks over, for bus and divider phase
  task automatic t_clocks();
    wr(`ARTT_OFS_CLKSEL, 32'h2, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_CONTROL, 32'h0c, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_COUNT, 32'h0, `ARTT_RESP_OKAY);
    repeat (120) @(posedge aclk);
    rd(`ARTT_OFS_COUNT, d, r);
    cmp(32'(d[15:8] >= 8'd120 && d[15:8] < 8'd131), 32'h1, "fast");
    cmp(32'(d[7:0] >= 8'd9 && d[7:0] < 8'd12), 32'h1, "div12");
    wr(`ARTT_OFS_CONTROL, 32'h09, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_CLKSEL, 32'h0, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_COUNT, 32'h0, `ARTT_RESP_OKAY);
    repeat (640) @(posedge aclk);
    rd(`ARTT_OFS_COUNT, d, r);
    cmp(32'(d[7:0] >= 8'd9 && d[7:0] < 8'd12), 32'h1, "ext8");
    cmp(32'(d[15:8]), 32'h0, "high stopped");
  endtask : t_clocks

  // a low reload of 0xff wraps the low half on every core clock, so the
  // status clear is bound to meet a hardware set in the same cycle
  task automatic t_race();
    wr(`ARTT_OFS_RELOAD, 32'h12ff, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_CLKSEL, 32'h1, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_CONTROL, 32'h08, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_COUNT, 32'h00ff, `ARTT_RESP_OKAY);
    wr(`ARTT_OFS_STATUS, 32'h40, `ARTT_RESP_OKAY);
    rdc(`ARTT_OFS_STATUS, 32'h40);
    rdc(`ARTT_OFS_COUNT, 32'h00ff);
  endtask : t_race

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata  = 32'h0;
    wstrb  = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_wide();
    t_split();
    t_clocks();
    t_race();
    final_report();
  end

endmodule : test_auto_reload_timer_two
